// ===== sfr_consts.svh
// Notes on behaviour
// R1: five defined states, all reachable
// R2: five-bit one-hot state register encoding
// R3: reset loads state 0 asynchronously
// R4: ring advance when input high, else hold
// R5: any invalid pattern forces back to 0
// R6: invalid state sets rising-edge flag
// R7: falling edge copies first flag onward
// R8: second flag ORed with reset clears state
// R9: flags clear on next edges after recovery
// R10: forced reset comes from falling-edge flop
// R11: detection is combinational, not exactly one
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// ---------------------------------------------------------------
// state encodings
// ---------------------------------------------------------------
`define SFR_ENC_S0 5'h01
`define SFR_ENC_S1 5'h02
`define SFR_ENC_S2 5'h04
`define SFR_ENC_S3 5'h08
`define SFR_ENC_S4 5'h10

// ---------------------------------------------------------------
// state index values shown on the output
// ---------------------------------------------------------------
`define SFR_IDX_S0 3'h0
`define SFR_IDX_S1 3'h1
`define SFR_IDX_S2 3'h2
`define SFR_IDX_S3 3'h3
`define SFR_IDX_S4 3'h4

`endif

// ===== sfr_pkg.sv
`default_nettype none
`include "sfr_consts.svh"

package sfr_pkg;

   // one-hot state names
   typedef enum logic [4:0] {
      SFR_ST0 = `SFR_ENC_S0,
      SFR_ST1 = `SFR_ENC_S1,
      SFR_ST2 = `SFR_ENC_S2,
      SFR_ST3 = `SFR_ENC_S3,
      SFR_ST4 = `SFR_ENC_S4
   } sfr_state_t;

   // posedge state of the machine
   typedef struct packed {
      logic [4:0] state; // raw pattern, may be upset
      logic [2:0] index; // registered state index
   } sfr_regs_t;

endpackage

`default_nettype wire

// ===== sfr_fsm.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfr_consts.svh"

module sfr_fsm
   import sfr_pkg::*;
(
   input wire logic sys_clk, // 25 MHz clock, both edges used
   input wire logic reset_n, // active-low reset
   input wire logic advance_input, // step the ring when high
   output logic [2:0] state_index_out // current state index
);

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------

   // true only for exactly one bit set; all zeros is illegal too
   function automatic logic sfr_onehot_ok(input logic [4:0] s);
      return ($countones(s) == 1); // R11
   endfunction

   // index of a one-hot pattern; illegal patterns read as zero
   function automatic logic [2:0] sfr_index(input logic [4:0] s);
      case (s)
         `SFR_ENC_S1: return `SFR_IDX_S1;
         `SFR_ENC_S2: return `SFR_IDX_S2;
         `SFR_ENC_S3: return `SFR_IDX_S3;
         `SFR_ENC_S4: return `SFR_IDX_S4;
         default: return `SFR_IDX_S0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   sfr_regs_t cur; // registered state
   sfr_regs_t next_cur; // next value
   logic illegal_flag_rise; // invalid seen, rising edge
   logic illegal_flag_fall; // copy on falling edge
   logic force_reset; // merged asynchronous clear
   logic state_bad; // current pattern invalid

   assign state_bad = !sfr_onehot_ok(cur.state); // R5 R11
   assign state_index_out = cur.index;

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------

   // ring 0..4; an invalid pattern simply holds, recovery comes from
   // the flag pipeline so the ring logic stays a plain shifter
   always_comb begin
      next_cur = cur;
      case (cur.state)
         SFR_ST0: begin
            next_cur.state = advance_input ? SFR_ST1 : SFR_ST0; // R4
         end
         SFR_ST1: begin
            next_cur.state = advance_input ? SFR_ST2 : SFR_ST1; // R4
         end
         SFR_ST2: begin
            next_cur.state = advance_input ? SFR_ST3 : SFR_ST2; // R4
         end
         SFR_ST3: begin
            next_cur.state = advance_input ? SFR_ST4 : SFR_ST3; // R4
         end
         SFR_ST4: begin
            next_cur.state = advance_input ? SFR_ST0 : SFR_ST4; // R1 R4
         end
         default: begin
            next_cur.state = cur.state; // left to the recovery path
         end
      endcase
      next_cur.index = sfr_index(next_cur.state); // R4
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------

   // the merged clear acts without the clock; reset_n releases it directly,
   // the recovery term from the falling-edge flop, half a period from the edge
   assign force_reset = !reset_n || illegal_flag_fall; // R8 R10

   always_ff @(posedge sys_clk or posedge force_reset) begin
      if (force_reset) begin
         cur.state <= `SFR_ENC_S0; // R3 R8
         cur.index <= `SFR_IDX_S0;
      end else begin
         cur <= next_cur; // R2 R3
      end
   end

   // ---------------------------------------------------------------
   // recovery flag pipeline
   // ---------------------------------------------------------------

   // the flags clear on the clock, not at once: while reset is low the
   // merged clear already holds the state, so nothing waits on them
   // first flag: sampled invalid pattern on the rising edge
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         illegal_flag_rise <= 1'b0;
      end else begin
         illegal_flag_rise <= state_bad; // R6 R9
      end
   end

   // second flag: retimed on the falling edge to keep the release safe
   always_ff @(negedge sys_clk) begin
      if (!reset_n) begin
         illegal_flag_fall <= 1'b0;
      end else begin
         illegal_flag_fall <= illegal_flag_rise; // R7 R9 R10
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   logic quiet; // valid state and no recovery pending
   assign quiet = sfr_onehot_ok(cur.state) && !illegal_flag_rise &&
                  !illegal_flag_fall;

   AST_RESET_S0: assert property (@(posedge sys_clk) // R3
      $rose(reset_n) |-> cur.state == `SFR_ENC_S0)
      else $error("state not 0 after reset");

   AST_ADVANCE: assert property (@(posedge sys_clk) // R4
      disable iff (!reset_n)
      quiet && advance_input |=>
      cur.state == {$past(cur.state[3:0]), $past(cur.state[4])})
      else $error("ring did not advance");

   AST_HOLD: assert property (@(posedge sys_clk) // R4
      disable iff (!reset_n)
      quiet && !advance_input |=> $stable(cur.state))
      else $error("state moved without advance");

   AST_INDEX: assert property (@(posedge sys_clk) // R2
      disable iff (!reset_n)
      sfr_onehot_ok(cur.state) |->
      cur.state == (`SFR_ENC_S0 << state_index_out))
      else $error("index does not match state");

   AST_FLAG_SET: assert property (@(posedge sys_clk) // R6
      disable iff (!reset_n)
      state_bad |=> illegal_flag_rise)
      else $error("invalid state not flagged");

   AST_FALL_COPY: assert property (@(posedge sys_clk) // R7
      disable iff (!reset_n)
      $rose(illegal_flag_rise) |-> illegal_flag_fall)
      else $error("falling flag did not follow");

   AST_FORCE_S0: assert property (@(posedge sys_clk) // R8
      disable iff (!reset_n)
      illegal_flag_fall |-> cur.state == `SFR_ENC_S0)
      else $error("recovery did not force state 0");

   AST_FLAGS_CLEAR: assert property (@(posedge sys_clk) // R9
      disable iff (!reset_n)
      $rose(illegal_flag_rise) |=>
      !illegal_flag_rise && !illegal_flag_fall ##1 quiet)
      else $error("recovery flags did not clear");

   AST_NOT_STUCK: assert property (@(posedge sys_clk) // R5
      disable iff (!reset_n)
      state_bad |-> ##1 cur.state == `SFR_ENC_S0 ##1 quiet)
      else $error("machine stuck in invalid state");

   AST_FALL_SOURCE: assert property (@(posedge sys_clk) // R10
      disable iff (!reset_n)
      $rose(illegal_flag_fall) |-> $rose(illegal_flag_rise))
      else $error("forced reset without rising flag");

   // the index never leaves the five-value range
   AST_INDEX_RANGE: assert property (@(posedge sys_clk) // R4
      disable iff (!reset_n)
      state_index_out <= `SFR_IDX_S4)
      else $error("index out of range");

   // the falling-edge flop always shows what the rising one held
   AST_FALL_TRACK: assert property (@(posedge sys_clk) // R7
      disable iff (!reset_n)
      illegal_flag_fall == illegal_flag_rise)
      else $error("falling flag does not track");

   // a valid pattern leaves no flag behind on the next edge
   AST_RISE_CLEAR: assert property (@(posedge sys_clk) // R9
      disable iff (!reset_n)
      !state_bad |=> !illegal_flag_rise)
      else $error("rising flag set without cause");

   // a valid state never steps into an invalid one
   AST_NEXT_ONEHOT: assert property (@(posedge sys_clk) // R2
      disable iff (!reset_n)
      !state_bad |-> sfr_onehot_ok(next_cur.state))
      else $error("next state is not one-hot");

   // cover points: one per main scenario
   COV_RING: cover property (@(posedge sys_clk) disable iff (!reset_n)
      cur.state == `SFR_ENC_S4 && advance_input && quiet ##1
      cur.state == `SFR_ENC_S0);

   COV_HOLD: cover property (@(posedge sys_clk) disable iff (!reset_n)
      quiet && !advance_input [*3]);

   COV_RECOVER: cover property (@(posedge sys_clk) disable iff (!reset_n)
      state_bad ##1 illegal_flag_fall ##1 quiet);

   // a lap visits states 1 to 4 in turn, one per cycle
   COV_LAP: cover property (@(posedge sys_clk) disable iff (!reset_n)
      cur.state == `SFR_ENC_S1 ##1 cur.state == `SFR_ENC_S2 ##1
      cur.state == `SFR_ENC_S3 ##1 cur.state == `SFR_ENC_S4);

   // advance already high at the edge that ends reset
   COV_RELEASE_STEP: cover property (@(posedge sys_clk)
      $rose(reset_n) && advance_input ##1 cur.state == `SFR_ENC_S1);

endmodule

`default_nettype wire

// ===== sfr_adv_src.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------
// upstream source of the advance level
// ----------------------------------------------
module sfr_adv_src (
   input wire logic sys_clk, // block clock
   output logic advance_input // step request, level
);
   // starts low so no step is taken out of reset by accident
   initial advance_input = 1'b0;

   // called at a rising edge; changes the level just after it
   task automatic drive(input logic v);
      #1 advance_input = v;
   endtask
endmodule

`default_nettype wire

// ===== sfr_fsm_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfr_consts.svh"

module sfr_fsm_tb;
   import sfr_pkg::*;
   logic sys_clk = 1'b0; // 25 MHz
   logic reset_n = 1'b0; // active-low reset
   wire logic advance_input; // from the source model
   logic [2:0] state_index_out; // index seen
   int n_fail = 0; // mismatch count
   int samples_checked = 0; // compare count
   logic [31:0] lfsr = 32'h3be2; // random source
   logic [2:0] exp_idx = 3'h0; // model of the ring
   logic [2:0] q[$]; // expected index per edge

   always #20 sys_clk = ~sys_clk;

   sfr_fsm sfr_fsm_i (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .advance_input(advance_input),
      .state_index_out(state_index_out)
   );

   sfr_adv_src sfr_adv_src_i (
      .sys_clk(sys_clk),
      .advance_input(advance_input)
   );

   // ----------------------------------------------
   // helpers
   // ----------------------------------------------
   task automatic check(input string nm, input logic [2:0] seen,
                        input logic [2:0] expv);
      samples_checked++;
      if (seen !== expv) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, expv, seen);
      end
   endtask

   task automatic end_of_test;
      if (q.size() != 0) n_fail++;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   function automatic logic [31:0] nxt(input logic [31:0] l);
      return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
   endfunction

   // one cycle: drive, model the ring, note the result of the edge
   task automatic cyc(input logic v);
      sfr_adv_src_i.drive(v);
      if (v) begin
         exp_idx = (exp_idx === `SFR_IDX_S4) ? `SFR_IDX_S0 : exp_idx + 3'h1;
      end
      @(posedge sys_clk);
      q.push_back(exp_idx);
   endtask

   // ----------------------------------------------
   // monitor: result settles just after each edge
   // ----------------------------------------------
   always @(posedge sys_clk) begin
      #2;
      if (q.size() > 0) begin
         check("state_index_out", state_index_out, q.pop_front());
      end
   end

   // hang guard, far beyond the few hundred cycles used
   initial begin
      #80000;
      n_fail++;
      end_of_test();
   end

   // ----------------------------------------------
   // main sequence
   // ----------------------------------------------
   initial begin
      repeat (8) @(posedge sys_clk);
      #1 check("reset index", state_index_out, `SFR_IDX_S0);
      reset_n = 1'b1;
      @(posedge sys_clk);
      // back-to-back steps: two full laps visit all five states
      for (int i = 0; i < 10; i++) cyc(1'b1);
      // random mix of steps and holds
      for (int i = 0; i < 300; i++) begin
         lfsr = nxt(lfsr);
         cyc(lfsr[0]);
      end
      cyc(1'b1);
      // let the last note be compared before reset hides it
      @(posedge sys_clk);
      // reset dropped between edges must clear without a clock
      #1 reset_n = 1'b0;
      #4 check("async reset", state_index_out, `SFR_IDX_S0);
      exp_idx = `SFR_IDX_S0;
      repeat (2) @(posedge sys_clk);
      // advance stays high, so the first edge after release steps
      sfr_adv_src_i.drive(1'b1);
      reset_n = 1'b1;
      exp_idx = `SFR_IDX_S1;
      @(posedge sys_clk);
      q.push_back(exp_idx);
      for (int i = 0; i < 6; i++) cyc(1'b1);
      @(posedge sys_clk);
      #5 end_of_test();
   end
endmodule

`default_nettype wire
